// File: common/lccp_pkg.sv
// Constants shared by the caption decoder serial port controller and its shift engine.
// Assumes a 100 MHz system clock; all times are turned into cycle counts here.
package lccp_pkg;

  localparam int CLK_NS        = 10;
  localparam int RST_HOLD_NS   = 100;
  localparam int EN_GAP_NS     = 100;
  localparam int BLIND_GAP_MS  = 66;
  localparam int HALF_CYC_DEF  = 16;

  // Least times round up to whole cycles and never fall below one.
  function automatic int cyc_min(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int RST_HOLD_CYC  = cyc_min(RST_HOLD_NS);
  localparam int EN_GAP_CYC    = cyc_min(EN_GAP_NS);
  localparam int BLIND_GAP_CYC = (BLIND_GAP_MS * 1000000) / CLK_NS;

  // Command bytes understood by the device.
  localparam logic [7:0] CMD_NOP    = 8'h00;
  localparam logic [7:0] CMD_FETCH1 = 8'hF8;
  localparam logic [7:0] CMD_FETCH2 = 8'hF9;
  localparam logic [7:0] CMD_SYNCFF = 8'hFF;
  localparam logic [7:0] CMD_SYNCFE = 8'hFE;
  localparam logic [7:0] CMD_RST0   = 8'hFB;
  localparam logic [7:0] CMD_RST1   = 8'hFC;
  localparam logic [3:0] CAPTION_TEXT_SELECT_HIGH  = 4'h1;

  // Operations that software starts through the command register.
  localparam logic [2:0] OP_BYTE  = 3'h0;
  localparam logic [2:0] OP_SYNC  = 3'h1;
  localparam logic [2:0] OP_HWRST = 3'h2;
  localparam logic [2:0] OP_SWRST = 3'h3;
  localparam logic [2:0] OP_READ  = 3'h4;
  localparam logic [2:0] OP_CAPTION_TEXT_SELECT  = 3'h5;

  // Register byte offsets, field positions and the config register reset value.
  localparam logic [3:0] ADDR_CMD  = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h4;
  localparam logic [3:0] ADDR_DATA = 4'h8;
  localparam logic [3:0] ADDR_CFG  = 4'hC;
  localparam int CMD_OP_LSB    = 8;
  localparam int STAT_BUSY     = 8;
  localparam int STAT_RDYPIN   = 9;
  localparam int STAT_NODATA   = 10;
  localparam int STAT_TWO      = 11;
  localparam int CFG_EN        = 0;
  localparam int CFG_BLIND     = 1;
  localparam logic [1:0] CFG_RESET = 2'h1;

  // Bit positions inside the serial status byte.
  localparam int SS_RDY = 7;
  localparam int SS_DAV = 6;
  localparam int SS_RD2 = 5;

  // Last byte index of each operation, and the fetch and first data byte indices of a read.
  localparam logic [1:0] LAST_ONE   = 2'h0;
  localparam logic [1:0] LAST_THREE = 2'h2;
  localparam logic [1:0] LAST_RD1   = 2'h2;
  localparam logic [1:0] LAST_RD2   = 2'h3;
  localparam logic [1:0] IDX_FETCH  = 2'h1;
  localparam logic [1:0] IDX_DATA0  = 2'h2;

endpackage

// File: common/lccp_sh_if.sv
// Byte transfer request and answer between the controller and its shift engine.
// Assumes both ends run on the same system clock.
interface lccp_sh_if;
  logic       start;
  logic [7:0] tx;
  logic       dout;
  logic       done;
  logic [7:0] rx;
  logic       sck;
  logic       sdi;

  modport ctl (output start, output tx, output dout, input done, input rx, input sck, input sdi);
  modport eng (input start, input tx, input dout, output done, output rx, output sck, output sdi);
endinterface

// File: verilog/lccp_shift.sv
// Shift engine: makes the serial clock by a divider and moves one byte each way.
// Assumes the data-out level it receives is already synchronised.
module lccp_shift
  import lccp_pkg::*;
#(
  parameter int HALF_CYC = HALF_CYC_DEF
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  lccp_sh_if.eng   sh
);

  typedef enum logic [2:0] {
    SH_IDLE = 3'b001,
    SH_LOW  = 3'b010,
    SH_HIGH = 3'b100
  } lccp_sh_e;

  localparam logic [15:0] HALF_LD = 16'(HALF_CYC - 1);

  lccp_sh_e    state;
  lccp_sh_e    next_state;
  logic [15:0] tmr;
  logic [15:0] next_tmr;
  logic [2:0]  cnt;
  logic [2:0]  next_cnt;
  logic [7:0]  sreg;
  logic [7:0]  next_sreg;
  logic [7:0]  rreg;
  logic [7:0]  next_rreg;
  logic        sck;
  logic        next_sck;
  logic        sdi;
  logic        next_sdi;
  logic        done;
  logic        next_done;

  always_comb begin
    next_state = state;
    next_tmr   = tmr;
    next_cnt   = cnt;
    next_sreg  = sreg;
    next_rreg  = rreg;
    next_sck   = sck;
    next_sdi   = sdi;
    next_done  = 1'b0;
    case (state)
      SH_IDLE: begin
        if (sh.start) begin
          next_sreg  = sh.tx;
          next_sdi   = sh.tx[7];
          next_cnt   = 3'h0;
          next_tmr   = HALF_LD;
          next_state = SH_LOW;
        end
      end
      SH_LOW: begin
        if (tmr == 16'h0000) begin
          // The device changes its output on rising edges, so take it just before one.
          next_rreg  = {rreg[6:0], sh.dout};
          next_sck   = 1'b1;
          next_tmr   = HALF_LD;
          next_state = SH_HIGH;
        end else begin
          next_tmr = tmr - 16'h0001;
        end
      end
      SH_HIGH: begin
        if (tmr == 16'h0000) begin
          next_sck = 1'b0;
          if (cnt == 3'h7) begin
            next_done  = 1'b1;
            next_state = SH_IDLE;
          end else begin
            next_cnt   = cnt + 3'h1;
            next_sreg  = {sreg[6:0], 1'b0};
            next_sdi   = sreg[6];
            next_tmr   = HALF_LD;
            next_state = SH_LOW;
          end
        end else begin
          next_tmr = tmr - 16'h0001;
        end
      end
      default: next_state = SH_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= SH_IDLE;
      tmr   <= 16'h0000;
      cnt   <= 3'h0;
      sreg  <= 8'h00;
      rreg  <= 8'h00;
      sck   <= 1'b0;
      sdi   <= 1'b0;
      done  <= 1'b0;
    end else if (i_ce) begin
      state <= next_state;
      tmr   <= next_tmr;
      cnt   <= next_cnt;
      sreg  <= next_sreg;
      rreg  <= next_rreg;
      sck   <= next_sck;
      sdi   <= next_sdi;
      done  <= next_done;
    end
  end

  assign sh.done = done;
  assign sh.rx   = rreg;
  assign sh.sck  = sck;
  assign sh.sdi  = sdi;

endmodule

// File: verilog/lccp_host.sv
// Host controller for the serial command port of a line-21 caption decoder.
// Assumes software on an Avalon-MM bus and the decoder wired to the pin ports.
//
// Local design decisions: the Avalon-MM register port and the placing of the registers.
module lccp_host
  import lccp_pkg::*;
#(
  parameter int HALF_CYC  = HALF_CYC_DEF,
  parameter int BLIND_CYC = BLIND_GAP_CYC
) (
  input  wire logic        I_CLK,
  input  wire logic        I_RSTN,
  input  wire logic        I_CE,
  input  wire logic [3:0]  I_AVS_ADDRESS,
  input  wire logic        I_AVS_READ,
  input  wire logic        I_AVS_WRITE,
  input  wire logic [31:0] I_AVS_WRITEDATA,
  output logic      [31:0] O_AVS_READDATA,
  output logic             O_AVS_WAITREQUEST,
  output logic             O_SCK,
  output logic             O_SDI,
  input  wire logic        I_SDO,
  output logic             O_PORT_EN,
  output logic             O_MODE_SEL
);

  typedef enum logic [6:0] {
    ST_IDLE  = 7'b0000001,
    ST_RST   = 7'b0000010,
    ST_GAP   = 7'b0000100,
    ST_RDY   = 7'b0001000,
    ST_SEND  = 7'b0010000,
    ST_WAIT  = 7'b0100000,
    ST_SPACE = 7'b1000000
  } lccp_st_e;

  localparam logic [31:0] RST_LD   = 32'(RST_HOLD_CYC - 1);
  localparam logic [31:0] GAP_LD   = 32'(EN_GAP_CYC - 1);
  localparam logic [31:0] BLIND_LD = 32'(BLIND_CYC - 1);
  // Cycles that the data-out level needs to cross both synchroniser stages after enable.
  localparam logic [31:0] PIN_SETTLE_LD = 32'h00000002;

  // Byte number idx of the operation; the read sequence depends on the status seen.
  function automatic logic [7:0] seq_byte(input logic [2:0] op, input logic [1:0] idx,
                                          input logic [7:0] arg, input logic two);
    case (op)
      OP_SYNC, OP_HWRST: seq_byte = (idx == LAST_THREE) ? CMD_SYNCFE : CMD_SYNCFF;
      OP_SWRST: seq_byte = (idx == 2'h0) ? CMD_RST0 : ((idx == 2'h1) ? CMD_RST1 : CMD_NOP);
      OP_READ:  seq_byte = (idx == IDX_FETCH) ? (two ? CMD_FETCH2 : CMD_FETCH1) : CMD_NOP;
      OP_CAPTION_TEXT_SELECT:  seq_byte = {CAPTION_TEXT_SELECT_HIGH, arg[3:0]};
      default:  seq_byte = arg;
    endcase
  endfunction

  function automatic logic [1:0] seq_last(input logic [2:0] op, input logic two);
    case (op)
      OP_SYNC, OP_HWRST, OP_SWRST: seq_last = LAST_THREE;
      OP_READ: seq_last = two ? LAST_RD2 : LAST_RD1;
      default: seq_last = LAST_ONE;
    endcase
  endfunction

  // No-op and fetch bytes, and all bytes of the sync, reset and read operations, go out whatever the ready level is.
  function automatic logic needs_ready(input logic [2:0] op, input logic [7:0] b);
    needs_ready = ((op == OP_BYTE) && (b != CMD_NOP) && (b != CMD_FETCH1) &&
                   (b != CMD_FETCH2)) || (op == OP_CAPTION_TEXT_SELECT);
  endfunction

  lccp_sh_if sh ();

  lccp_shift #(
    .HALF_CYC (HALF_CYC)
  ) u_shift (
    .i_clk  (I_CLK),
    .i_rstn (I_RSTN),
    .i_ce   (I_CE),
    .sh     (sh.eng)
  );

  logic        sdo_m;
  logic        sdo_s;
  lccp_st_e    state;
  lccp_st_e    next_state;
  logic [31:0] tmr;
  logic [31:0] next_tmr;
  logic [2:0]  op;
  logic [2:0]  next_op;
  logic [7:0]  arg;
  logic [7:0]  next_arg;
  logic [1:0]  idx;
  logic [1:0]  next_idx;
  logic        two;
  logic        next_two;
  logic        nodata;
  logic        next_nodata;
  logic [7:0]  status;
  logic [7:0]  next_status;
  logic [15:0] rdata;
  logic [15:0] next_rdata;
  logic        port_en;
  logic        next_port_en;
  logic        mode_sel;
  logic        next_mode_sel;
  logic        start;
  logic        next_start;
  logic [7:0]  tx;
  logic [7:0]  next_tx;
  logic [1:0]  cfg;
  logic [1:0]  next_cfg;
  logic        waitreq;
  logic        next_waitreq;
  logic [31:0] rd;
  logic [31:0] next_rd;
  logic        cmd_go;
  logic        next_cmd_go;
  logic [7:0]  cur_byte;
  logic        stall;
  logic        finish;

  // The data-out pin crosses in from the device through two flip-flops.
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      sdo_m <= 1'b0;
      sdo_s <= 1'b0;
    end else if (I_CE) begin
      sdo_m <= I_SDO;
      sdo_s <= sdo_m;
    end
  end

  assign cur_byte = seq_byte(op, idx, arg, two);
  assign finish   = (idx == seq_last(op, two));
  assign stall    = (I_AVS_ADDRESS == ADDR_CMD) && ((state != ST_IDLE) || cmd_go);

  // Avalon slave: waitrequest drops one cycle after a request, or once idle for a command write while busy, and the access ends there.
  always_comb begin
    next_waitreq = 1'b1;
    next_rd      = rd;
    next_cfg     = cfg;
    next_cmd_go  = 1'b0;
    if ((I_AVS_READ || I_AVS_WRITE) && waitreq) begin
      if (!(I_AVS_WRITE && stall)) begin
        next_waitreq = 1'b0;
      end
      case (I_AVS_ADDRESS)
        ADDR_CMD:  next_rd = {21'h000000, op, arg};
        ADDR_STAT: next_rd = {20'h00000, two, nodata, sdo_s, (state != ST_IDLE), status};
        ADDR_DATA: next_rd = {16'h0000, rdata};
        ADDR_CFG:  next_rd = {30'h00000000, cfg};
        default:   next_rd = 32'h00000000;
      endcase
    end
    if (I_AVS_WRITE && !waitreq) begin
      if (I_AVS_ADDRESS == ADDR_CMD) begin
        next_cmd_go = 1'b1;
      end
      if (I_AVS_ADDRESS == ADDR_CFG) begin
        next_cfg = I_AVS_WRITEDATA[1:0];
      end
    end
  end

  always_comb begin
    next_state    = state;
    next_tmr      = tmr;
    next_op       = op;
    next_arg      = arg;
    next_idx      = idx;
    next_two      = two;
    next_nodata   = nodata;
    next_status   = status;
    next_rdata    = rdata;
    next_port_en  = port_en;
    next_mode_sel = mode_sel;
    next_start    = 1'b0;
    next_tx       = tx;
    case (state)
      ST_IDLE: begin
        // A drop and rise of the enable pin also realigns the device's bit count.
        next_port_en = cfg[CFG_EN];
        if (cmd_go) begin
          next_op  = I_AVS_WRITEDATA[CMD_OP_LSB +: 3];
          next_arg = I_AVS_WRITEDATA[7:0];
          next_idx = 2'h0;
          next_two = 1'b0;
          if (I_AVS_WRITEDATA[CMD_OP_LSB +: 3] == OP_HWRST) begin
            next_port_en  = 1'b0;
            next_mode_sel = 1'b0;
            next_tmr      = RST_LD;
            next_state    = ST_RST;
          end else begin
            if (I_AVS_WRITEDATA[CMD_OP_LSB +: 3] == OP_READ) begin
              next_nodata = 1'b0;
            end
            // An operation always runs with the port enabled; a freshly enabled pin
            // must settle through the synchroniser before ready is trusted.
            next_port_en = 1'b1;
            next_tmr     = PIN_SETTLE_LD;
            next_state   = port_en ? ST_RDY : ST_GAP;
          end
        end
      end
      ST_RST: begin
        if (tmr == 32'h00000000) begin
          next_mode_sel = 1'b1;
          next_tmr      = GAP_LD;
          next_state    = ST_GAP;
        end else begin
          next_tmr = tmr - 32'h00000001;
        end
      end
      ST_GAP: begin
        if (tmr == 32'h00000000) begin
          next_port_en = 1'b1;
          next_idx     = 2'h0;
          next_state   = ST_RDY;
        end else begin
          next_tmr = tmr - 32'h00000001;
        end
      end
      ST_RDY: begin
        // Ready is read straight off the idle data-out pin, with no clocking.
        if (!needs_ready(op, cur_byte) || cfg[CFG_BLIND] || sdo_s) begin
          next_start = 1'b1;
          next_tx    = cur_byte;
          next_state = ST_SEND;
        end
      end
      ST_SEND: begin
        next_state = ST_WAIT;
      end
      ST_WAIT: begin
        if (sh.done) begin
          next_state = ST_RDY;
          next_idx   = idx + 2'h1;
          if ((op == OP_READ) && (idx >= IDX_DATA0)) begin
            // Data bytes come back under no-ops; all of them are taken so DATA_AVAILABLE_FLAG clears.
            next_rdata = (idx == IDX_DATA0) ? {sh.rx, 8'h00} : {rdata[15:8], sh.rx};
          end else if ((op != OP_READ) || (idx == 2'h0)) begin
            next_status = sh.rx;
          end
          if ((op == OP_READ) && (idx == 2'h0)) begin
            next_two = sh.rx[SS_RD2];
            if (!sh.rx[SS_DAV]) begin
              next_nodata = 1'b1;
              next_state  = cfg[CFG_BLIND] ? ST_SPACE : ST_IDLE;
              next_tmr    = BLIND_LD;
            end
          end else if (finish) begin
            next_state = cfg[CFG_BLIND] ? ST_SPACE : ST_IDLE;
            next_tmr   = BLIND_LD;
          end
        end
      end
      ST_SPACE: begin
        if (tmr == 32'h00000000) begin
          next_state = ST_IDLE;
        end else begin
          next_tmr = tmr - 32'h00000001;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // Leaving reset the controller holds the pins low, then syncs the port by itself.
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      state    <= ST_RST;
      tmr      <= RST_LD;
      op       <= OP_HWRST;
      arg      <= 8'h00;
      idx      <= 2'h0;
      two      <= 1'b0;
      nodata   <= 1'b0;
      status   <= 8'h00;
      rdata    <= 16'h0000;
      port_en  <= 1'b0;
      mode_sel <= 1'b0;
      start    <= 1'b0;
      tx       <= 8'h00;
      cfg      <= CFG_RESET;
      waitreq  <= 1'b1;
      rd       <= 32'h00000000;
      cmd_go   <= 1'b0;
    end else if (I_CE) begin
      state    <= next_state;
      tmr      <= next_tmr;
      op       <= next_op;
      arg      <= next_arg;
      idx      <= next_idx;
      two      <= next_two;
      nodata   <= next_nodata;
      status   <= next_status;
      rdata    <= next_rdata;
      port_en  <= next_port_en;
      mode_sel <= next_mode_sel;
      start    <= next_start;
      tx       <= next_tx;
      cfg      <= next_cfg;
      waitreq  <= next_waitreq;
      rd       <= next_rd;
      cmd_go   <= next_cmd_go;
    end
  end

  assign sh.start = start;
  assign sh.tx    = tx;
  assign sh.dout  = sdo_s;

  assign O_AVS_READDATA    = rd;
  assign O_AVS_WAITREQUEST = waitreq;
  assign O_SCK             = sh.sck;
  assign O_SDI             = sh.sdi;
  assign O_PORT_EN         = port_en;
  assign O_MODE_SEL        = mode_sel;

endmodule

// File: sim/lccp_host_checker.sv
// Checker for the port controller pins and the register bus handshake.
// Assumes it is bound to lccp_host and sees only that module's ports.
module lccp_host_checker
  import lccp_pkg::*;
#(
  parameter int HALF_CYC = HALF_CYC_DEF
) (
  input wire logic        I_CLK,
  input wire logic        I_RSTN,
  input wire logic [3:0]  I_AVS_ADDRESS,
  input wire logic        I_AVS_READ,
  input wire logic        I_AVS_WRITE,
  input wire logic [31:0] O_AVS_READDATA,
  input wire logic        O_AVS_WAITREQUEST,
  input wire logic        O_SCK,
  input wire logic        O_SDI,
  input wire logic        O_PORT_EN,
  input wire logic        O_MODE_SEL
);
  logic [7:0] hi_n;
  logic [7:0] low_n;
  logic [7:0] mode_n;
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RSTN);
  // Lengths of the clock high phase, the pin reset and the mode-to-enable gap.
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      hi_n   <= 8'h00;
      low_n  <= 8'h00;
      mode_n <= 8'h00;
    end else begin
      hi_n   <= O_SCK ? hi_n + 8'h01 : 8'h00;
      low_n  <= (O_PORT_EN || O_MODE_SEL) ? 8'h00 : low_n + {7'h00, low_n != 8'hFF};
      mode_n <= !O_MODE_SEL ? 8'h00 : mode_n + {7'h00, mode_n != 8'hFF};
    end
  end
  property p_rst_hold;
    $rose(O_MODE_SEL) |-> low_n >= 8'(RST_HOLD_CYC);
  endproperty
  a_rst_hold: assert property (p_rst_hold)
    else $error("pin reset too short");
  property p_en_gap;
    $rose(O_PORT_EN) |-> mode_n >= 8'(EN_GAP_CYC);
  endproperty
  a_en_gap: assert property (p_en_gap)
    else $error("enable too soon after reset");
  property p_sck_en;
    O_SCK |-> O_PORT_EN && O_MODE_SEL;
  endproperty
  a_sck_en: assert property (p_sck_en)
    else $error("clock while port disabled");
  property p_en_mode;
    O_PORT_EN |-> O_MODE_SEL;
  endproperty
  a_en_mode: assert property (p_en_mode)
    else $error("enable without serial mode");
  property p_sdi_stable;
    O_SCK |-> $stable(O_SDI);
  endproperty
  a_sdi_stable: assert property (p_sdi_stable)
    else $error("data moved while clock high");
  property p_sck_high;
    $fell(O_SCK) |-> hi_n == 8'(HALF_CYC);
  endproperty
  a_sck_high: assert property (p_sck_high)
    else $error("clock high phase length wrong");
  property p_wait_one;
    !O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("waitrequest low too long");
  property p_wait_req;
    !O_AVS_WAITREQUEST |-> $past(I_AVS_READ) || $past(I_AVS_WRITE);
  endproperty
  a_wait_req: assert property (p_wait_req)
    else $error("answer without request");
  property p_unmapped;
    !O_AVS_WAITREQUEST && I_AVS_READ && I_AVS_ADDRESS[1:0] != 2'h0 |-> O_AVS_READDATA == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
endmodule

bind lccp_host lccp_host_checker #(.HALF_CYC(HALF_CYC)) u_chk (
  .I_CLK             (I_CLK),
  .I_RSTN            (I_RSTN),
  .I_AVS_ADDRESS     (I_AVS_ADDRESS),
  .I_AVS_READ        (I_AVS_READ),
  .I_AVS_WRITE       (I_AVS_WRITE),
  .O_AVS_READDATA    (O_AVS_READDATA),
  .O_AVS_WAITREQUEST (O_AVS_WAITREQUEST),
  .O_SCK             (O_SCK),
  .O_SDI             (O_SDI),
  .O_PORT_EN         (O_PORT_EN),
  .O_MODE_SEL        (O_MODE_SEL)
);

// File: sim/lccp_dev_model.sv
// Behavioural model of the caption decoder serial command port.
// Assumes the controller drives its pins; the data-out line has no pull.
module lccp_dev_model #(
  parameter int BUSY_NS = 300
) (
  input  wire logic        i_sck,
  input  wire logic        i_sdi,
  input  wire logic        i_en,
  input  wire logic        i_mode,
  output logic             o_sdo,
  output logic      [15:0] o_mon
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] sr, code, d0, d1, ob;
  logic [2:0] cnt, nff, dflt;
  logic [1:0] pend, rs;
  logic       rdy, data_available_flag, rd2, xds, live, last;

  function automatic logic [7:0] val(input logic [2:0] a);
    return {5'h15, a};
  endfunction

  task automatic dev_reset();
    {cnt, nff, dflt, pend, rs, data_available_flag, rd2, xds, code} = '0;
    rdy = 1'b1;
  endtask

  task automatic take(input logic [7:0] b);
    if (pend != 2'h0) begin
      {data_available_flag, rd2} = (pend == 2'h1) ? 2'b00 : {data_available_flag, rd2};
      d0   = d1;
      pend = pend - 2'h1;
    end
    rs  = (b == 8'hFE && nff >= 3'h2) ? 2'h0 : rs;
    nff = (b == 8'hFF && nff != 3'h7) ? nff + 3'h1 : 3'h0;
    if (b == 8'hFB)
      rs = 2'h1;
    else if (b == 8'hFC && rs == 2'h1)
      rs = 2'h2;
    else if (b == 8'h00 && rs == 2'h2)
      {rs, dflt, xds, code} = {2'h0, dflt + 3'h1, 9'h000};
    else
      rs = 2'h0;
    if (b[7:1] == 7'h7C) begin
      pend = data_available_flag ? 2'h1 + {1'b0, b[0]} : 2'h0;
    end else if (rdy && b[7:4] inside {4'h1, 4'h2, 4'h4, 4'h6}) begin
      code = b;
      xds  = (b[7:4] == 4'h2);
      if (b[6]) begin
        d0  = val(b[2:0]);
        d1  = b[5] ? val(b[2:0] + 3'h1) : 8'hFF;
        rd2 = b[5];
        data_available_flag = 1'b1;
      end
      rdy = 1'b0;
      fork
        #BUSY_NS rdy = 1'b1;
      join_none
    end
  endtask

  assign ob    = (pend != 2'h0) ? d0 : {rdy, data_available_flag, rd2, 5'h00};
  assign live  = ob[3'h7 - cnt];
  assign o_sdo = i_en ? live : ~last;
  assign o_mon = {xds, dflt, 4'h0, code};

  initial dev_reset();
  always @(live or i_en) begin
    if (i_en)
      last = live;
  end
  always @(i_en or i_mode) begin
    if (!i_en && !i_mode)
      dev_reset();
  end
  always @(posedge i_en) begin
    cnt = 3'h0;
  end
  always @(posedge i_sck) begin
    if (i_en && i_mode) begin
      sr = {sr[6:0], i_sdi};
      if (cnt == 3'h7)
        take(sr);
      cnt = cnt + 3'h1;
    end
  end
endmodule

// File: sim/test_lccp_host.sv
// Self-checking bench for the caption decoder port controller.
// Assumes the device model on the pins and the bound checker.
module test_lccp_host
  import lccp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [2:0]  op;
    logic [7:0]  arg;
    logic [1:0]  kind;
    logic [15:0] exp;
  } lccp_row_s;
  localparam lccp_row_s ROWS [17] = '{
    '{OP_CAPTION_TEXT_SELECT, 8'h07, 2'h0, 16'h0017}, '{OP_CAPTION_TEXT_SELECT, 8'h06, 2'h0, 16'h0016},
    '{OP_CAPTION_TEXT_SELECT, 8'h0F, 2'h0, 16'h001F}, '{OP_CAPTION_TEXT_SELECT, 8'h0E, 2'h0, 16'h001E},
    '{OP_CAPTION_TEXT_SELECT, 8'h03, 2'h0, 16'h0013}, '{OP_CAPTION_TEXT_SELECT, 8'h02, 2'h0, 16'h0012},
    '{OP_BYTE, 8'h23, 2'h0, 16'h8023}, '{OP_CAPTION_TEXT_SELECT, 8'h01, 2'h0, 16'h0011},
    '{OP_BYTE, 8'h43, 2'h0, 16'h0043}, '{OP_READ, 8'h00, 2'h1, 16'hAB00},
    '{OP_BYTE, 8'h65, 2'h0, 16'h0065}, '{OP_READ, 8'h00, 2'h1, 16'hADAE},
    '{OP_READ, 8'h00, 2'h2, 16'h0680}, '{OP_SWRST, 8'h00, 2'h0, 16'h1000},
    '{OP_SYNC, 8'h00, 2'h0, 16'h1000}, '{OP_BYTE, 8'h00, 2'h0, 16'h1000},
    '{OP_HWRST, 8'h00, 2'h0, 16'h0000}};
  logic        clk, rstn, ce, rd, wr, waitreq, sck, sdi, sdo, port_en, mode_sel;
  logic [3:0]  addr;
  logic [31:0] wdata, rdata, q;
  logic [15:0] mon;
  int          fail_count = 0;
  int          check_count = 0;

  lccp_host #(.HALF_CYC(2), .BLIND_CYC(40)) DUT (
    .I_CLK             (clk),
    .I_RSTN            (rstn),
    .I_CE              (ce),
    .I_AVS_ADDRESS     (addr),
    .I_AVS_READ        (rd),
    .I_AVS_WRITE       (wr),
    .I_AVS_WRITEDATA   (wdata),
    .O_AVS_READDATA    (rdata),
    .O_AVS_WAITREQUEST (waitreq),
    .O_SCK             (sck),
    .O_SDI             (sdi),
    .I_SDO             (sdo),
    .O_PORT_EN         (port_en),
    .O_MODE_SEL        (mode_sel)
  );
  lccp_dev_model #(.BUSY_NS(300)) u_dev (
    .i_sck  (sck),
    .i_sdi  (sdi),
    .i_en   (port_en),
    .i_mode (mode_sel),
    .o_sdo  (sdo),
    .o_mon  (mon)
  );

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wr    <= w;
    rd    <= ~w;
    wdata <= d;
    do
      @(posedge clk);
    while (waitreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wait_idle();
    do
      bus(1'b0, ADDR_STAT, 32'h0);
    while (q[STAT_BUSY] !== 1'b0);
  endtask

  task automatic run_op(input logic [2:0] op, input logic [7:0] arg);
    bus(1'b1, ADDR_CMD, {21'h0, op, arg});
    repeat (3) @(posedge clk);
    wait_idle();
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    $display("ERROR %0t watchdog expired", $time);
    stop_test();
  end
  initial begin
    {rstn, rd, wr, addr, wdata} = '0;
    ce = 1'b1;
    repeat (5) @(posedge clk);
    chk({27'h0, waitreq, port_en, mode_sel, sck, sdi}, 32'h10);
    rstn <= 1'b1;
    wait_idle();
    bus(1'b0, ADDR_CFG, 32'h0);
    chk(q, {30'h0, CFG_RESET});
    bus(1'b0, 4'h6, 32'h0);
    chk(q, 32'h0);
    $display("reset test done");
    foreach (ROWS[i]) begin
      run_op(ROWS[i].op, ROWS[i].arg);
      bus(1'b0, ADDR_CMD, 32'h0);
      chk(q, {21'h0, ROWS[i].op, ROWS[i].arg});
      case (ROWS[i].kind)
        2'h0: chk({16'h0, mon}, {16'h0, ROWS[i].exp});
        2'h1: begin
          bus(1'b0, ADDR_DATA, 32'h0);
          chk(q, {16'h0, ROWS[i].exp});
        end
        default: begin
          bus(1'b0, ADDR_STAT, 32'h0);
          chk({20'h0, q[11:0]}, {20'h0, ROWS[i].exp[11:0]});
        end
      endcase
      $display("row %0d done", i);
    end
    bus(1'b1, ADDR_CFG, 32'h3);
    bus(1'b0, ADDR_CFG, 32'h0);
    chk(q, 32'h3);
    run_op(OP_CAPTION_TEXT_SELECT, 8'h07);
    run_op(OP_CAPTION_TEXT_SELECT, 8'h06);
    chk({16'h0, mon}, 32'h16);
    $display("blind test done");
    bus(1'b1, ADDR_CFG, 32'h0);
    repeat (4) @(posedge clk);
    chk({31'h0, port_en}, 32'h0);
    run_op(OP_CAPTION_TEXT_SELECT, 8'h0F);
    chk({16'h0, mon}, 32'h1F);
    bus(1'b1, ADDR_CFG, 32'h1);
    $display("enable test done");
    bus(1'b1, ADDR_CMD, {21'h0, OP_CAPTION_TEXT_SELECT, 8'h07});
    repeat (40) @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    chk({27'h0, waitreq, port_en, mode_sel, sck, sdi}, 32'h10);
    rstn <= 1'b1;
    wait_idle();
    chk({16'h0, mon}, 32'h0);
    run_op(OP_CAPTION_TEXT_SELECT, 8'h03);
    chk({16'h0, mon}, 32'h13);
    $display("abort test done");
    stop_test();
  end
endmodule
